// ### hw/pdma_defs.svh
/*
 register offsets, field positions, reset values and codes of the dma block.
 assumes it is included by bare name from the design files.
*/
`ifndef PDMA_DEFS_SVH
`define PDMA_DEFS_SVH
`define PDMA_OFS_CON 3'h0
`define PDMA_OFS_REQ 3'h1
`define PDMA_OFS_STA 3'h2
`define PDMA_OFS_STB 3'h3
`define PDMA_OFS_PAD 3'h4
`define PDMA_OFS_CNT 3'h5
`define PDMA_OFS_CS0 5'h00
`define PDMA_OFS_CS1 5'h01
`define PDMA_OFS_RAD 5'h02
`define PDMA_CON_ON 15
`define PDMA_CON_SIZE 14
`define PDMA_CON_DIR 13
`define PDMA_CON_HALF 12
`define PDMA_CON_NULL_WRITE_MODE 11
`define PDMA_CON_ADDRESSING_SEL 5:4
`define PDMA_CON_MODE 1:0
`define PDMA_CON_MASK 16'hF833
`define PDMA_REQ_FORCE 15
`define PDMA_REQ_SEL 6:0
`define PDMA_SEL_RST 7'h7F
`define PDMA_CNT_MASK 16'h03FF
`define PDMA_LAST_NONE 4'hF
`define PDMA_AM_POSTINC 2'h0
`define PDMA_AM_NOINC 2'h1
`define PDMA_AM_PERIND 2'h2
`define PDMA_MD_CONT 2'h0
`define PDMA_MD_ONESHOT 2'h1
`define PDMA_MD_PPCONT 2'h2
`define PDMA_MD_PPONE 2'h3
`endif

// ### hw/pdma_pkg.sv
/*
 types shared by the dma controller files.
 assumes nothing beyond a systemverilog compiler.
*/
package pdma_pkg;
  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WAIT, ENG_WRITE} pdma_eng_t;
  typedef logic [1:0] pdma_chan_t;
  typedef logic [15:0] pdma_word_t;
endpackage

// ### hw/pdma_xfer_if.sv
/*
 request/answer bundle between channel control and transfer engine.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface pdma_xfer_if;
  import pdma_pkg::*;
  logic go;
  logic dir;
  logic bsize;
  logic null_write_mode;
  pdma_word_t ram_addr;
  pdma_word_t per_addr;
  logic done;
  logic pcol;
  logic rcol;
  modport ctl (output go, dir, bsize, null_write_mode, ram_addr, per_addr, input done, pcol, rcol);
  modport eng (input go, dir, bsize, null_write_mode, ram_addr, per_addr, output done, pcol, rcol);
endinterface

// ### hw/pdma_engine.sv
/*
 transfer engine: one read, then one write (ram plus a zero peripheral write in null write mode), on the dedicated bus.
 assumes both read ports return data one cycle after the read strobe.
*/
`timescale 1ns/1ns
`include "pdma_defs.svh"
module pdma_engine import pdma_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  pdma_xfer_if.eng xif,
  output logic per_req,
  output logic per_we,
  output logic per_byte,
  output pdma_word_t per_addr,
  output pdma_word_t per_wdata,
  input wire pdma_word_t per_rdata,
  input wire logic per_wcol,
  output logic ram_req,
  output logic ram_we,
  output logic ram_byte,
  output pdma_word_t ram_addr,
  output pdma_word_t ram_wdata,
  input wire pdma_word_t ram_rdata,
  input wire logic ram_wcol
);
  pdma_eng_t state_reg;
  logic dir_reg, null_write_mode_reg;
  pdma_word_t src_data;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign src_data = dir_reg ? ram_rdata : per_rdata;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ENG_IDLE;
      dir_reg <= 1'b0;
      null_write_mode_reg <= 1'b0;
      per_req <= 1'b0;
      per_we <= 1'b0;
      per_byte <= 1'b0;
      per_addr <= 16'h0000;
      per_wdata <= 16'h0000;
      ram_req <= 1'b0;
      ram_we <= 1'b0;
      ram_byte <= 1'b0;
      ram_addr <= 16'h0000;
      ram_wdata <= 16'h0000;
      xif.done <= 1'b0;
      xif.pcol <= 1'b0;
      xif.rcol <= 1'b0;
    end else if (clk_en) begin
      xif.done <= 1'b0;
      unique case (state_reg)
        ENG_IDLE: if (xif.go) begin
          dir_reg <= xif.dir;
          null_write_mode_reg <= xif.null_write_mode & ~xif.dir;
          per_addr <= xif.per_addr;
          ram_addr <= xif.ram_addr;
          per_byte <= xif.bsize;
          ram_byte <= xif.bsize;
          ram_req <= xif.dir;
          per_req <= ~xif.dir;
          ram_we <= 1'b0;
          per_we <= 1'b0;
          state_reg <= ENG_READ;
        end
        ENG_READ: begin
          ram_req <= 1'b0;
          per_req <= 1'b0;
          state_reg <= ENG_WAIT;
        end
        ENG_WAIT: begin
          // byte moves keep only the low lane
          per_wdata <= ram_byte ? {8'h00, src_data[7:0]} : src_data;
          ram_wdata <= ram_byte ? {8'h00, src_data[7:0]} : src_data;
          if (!dir_reg && null_write_mode_reg) begin
            per_wdata <= 16'h0000;
          end
          per_req <= dir_reg | null_write_mode_reg;
          per_we <= dir_reg | null_write_mode_reg;
          ram_req <= ~dir_reg;
          ram_we <= ~dir_reg;
          state_reg <= ENG_WRITE;
        end
        ENG_WRITE: begin
          xif.pcol <= per_we & per_wcol;
          xif.rcol <= ram_we & ram_wcol;
          per_req <= 1'b0;
          per_we <= 1'b0;
          ram_req <= 1'b0;
          ram_we <= 1'b0;
          xif.done <= 1'b1;
          state_reg <= ENG_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  sequence s_null_wr;
    ram_req && ram_we && per_req && per_we && per_wdata == 16'h0000;
  endsequence
  property p_null_write;
    (state_reg == ENG_IDLE && xif.go && !xif.dir && xif.null_write_mode) |=> per_req && !per_we ##2 s_null_wr;
  endproperty
  a_null_write: assert property (p_null_write) else $error("null write missing");
  sequence s_ram_rd;
    ram_req && !ram_we && !per_req;
  endsequence
  property p_dir_ram_to_per;
    (state_reg == ENG_IDLE && xif.go && xif.dir) |=> s_ram_rd ##2 (per_we && !ram_we);
  endproperty
  a_dir_ram_to_per: assert property (p_dir_ram_to_per) else $error("direction not honoured");
  property p_size;
    (state_reg == ENG_IDLE && xif.go) |=> (per_byte == $past(xif.bsize)) [*3];
  endproperty
  a_size: assert property (p_size) else $error("transfer size lost");
endmodule // pdma_engine

// ### hw/pdma_top.sv
/*
 four-channel peripheral dma controller with apb register access.
 assumes apb master per protocol, peripheral requests as one-cycle
 pulses and peripheral/ram read data one cycle after a read strobe.
*/
`timescale 1ns/1ns
`include "pdma_defs.svh"
module pdma_top import pdma_pkg::*; #(
  parameter int NCH = 4,
  parameter int NREQ = 128
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NREQ-1:0] periph_req,
  input wire pdma_word_t periph_ind_offs,
  output logic per_req,
  output logic per_we,
  output logic per_byte,
  output pdma_word_t per_addr,
  output pdma_word_t per_wdata,
  input wire pdma_word_t per_rdata,
  input wire logic per_wcol,
  output logic ram_req,
  output logic ram_we,
  output logic ram_byte,
  output pdma_word_t ram_addr,
  output pdma_word_t ram_wdata,
  input wire pdma_word_t ram_rdata,
  input wire logic ram_wcol,
  output logic [NCH-1:0] block_irq
);
  logic rst_s1_reg, rst_n;
  logic [15:0] ctl_reg [NCH];
  logic [15:0] sta_reg [NCH];
  logic [15:0] stb_reg [NCH];
  logic [15:0] pad_reg [NCH];
  logic [9:0] cnt_reg [NCH];
  logic [6:0] sel_reg [NCH];
  logic [9:0] idx_reg [NCH];
  logic [NCH-1:0] force_reg, pend_reg, pp_reg, periph_write_collision_reg, rwcol_reg, cand;
  logic [3:0] last_ch_reg;
  pdma_word_t recent_ram_address_reg;
  logic busy_reg, go_reg, forced_reg, any_cand;
  pdma_chan_t act_ch_reg, pick;
  logic [31:0] rd_val;
  logic rd_ok, commit, wr_commit;
  logic [2:0] reg_idx;
  pdma_word_t offs, base, go_ram_addr;
  pdma_xfer_if xif();

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  // registered answer keeps prdata/pready straight from flops
  assign commit = psel & penable & pready;
  assign wr_commit = commit & pwrite & rd_ok;
  assign reg_idx = paddr[4:2];
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b0;
    if (paddr[7]) begin
      rd_ok = (paddr[6:2] <= `PDMA_OFS_RAD) && (paddr[1:0] == 2'h0);
      if (paddr[6:2] == `PDMA_OFS_CS0) begin
        rd_val = {20'h0, periph_write_collision_reg, 4'h0, rwcol_reg};
      end else if (paddr[6:2] == `PDMA_OFS_CS1) begin
        rd_val = {20'h0, last_ch_reg, 4'h0, pp_reg};
      end else begin
        rd_val = {16'h0, recent_ram_address_reg};
      end
    end else begin
      rd_ok = (reg_idx <= `PDMA_OFS_CNT) && (paddr[1:0] == 2'h0);
      unique case (reg_idx)
        `PDMA_OFS_CON: rd_val = {16'h0, ctl_reg[paddr[6:5]]};
        `PDMA_OFS_REQ: rd_val = {16'h0, force_reg[paddr[6:5]], 8'h00, sel_reg[paddr[6:5]]};
        `PDMA_OFS_STA: rd_val = {16'h0, sta_reg[paddr[6:5]]};
        `PDMA_OFS_STB: rd_val = {16'h0, stb_reg[paddr[6:5]]};
        `PDMA_OFS_PAD: rd_val = {16'h0, pad_reg[paddr[6:5]]};
        `PDMA_OFS_CNT: rd_val = {22'h0, cnt_reg[paddr[6:5]]};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      prdata <= (rd_ok && !pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~rd_ok;
    end
  end

  // ----------------------------------------
  // per-channel registers and block state
  // ----------------------------------------
  genvar c;
  for (c = 0; c < NCH; c++) begin : g_ch
    logic wsel, done_c, last_c, stop_c, half_hit;
    logic [10:0] half_pt;
    assign wsel = wr_commit & ~paddr[7] & (paddr[6:5] == 2'(c));
    assign done_c = xif.done & (act_ch_reg == 2'(c));
    assign last_c = idx_reg[c] == cnt_reg[c];
    assign half_pt = ({1'b0, cnt_reg[c]} + 11'h001) >> 1;
    assign half_hit = ({1'b0, idx_reg[c]} + 11'h001) == half_pt;
    // stop after one block, or after the second buffer in one-shot ping-pong
    assign stop_c = (ctl_reg[c][`PDMA_CON_MODE] == `PDMA_MD_ONESHOT) ||
                    (ctl_reg[c][`PDMA_CON_MODE] == `PDMA_MD_PPONE && pp_reg[c]);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl_reg[c] <= 16'h0000;
      end else if (clk_en) begin
        if (wsel && reg_idx == `PDMA_OFS_CON) begin
          ctl_reg[c] <= pwdata[15:0] & `PDMA_CON_MASK;
        end else if (done_c && last_c && stop_c) begin
          ctl_reg[c][`PDMA_CON_ON] <= 1'b0;
        end
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        sta_reg[c] <= 16'h0000;
        stb_reg[c] <= 16'h0000;
        pad_reg[c] <= 16'h0000;
        cnt_reg[c] <= 10'h000;
        sel_reg[c] <= `PDMA_SEL_RST;
      end else if (clk_en && wsel) begin
        // rewriting pad/cnt mid-block is left to software discipline
        if (reg_idx == `PDMA_OFS_STA) sta_reg[c] <= pwdata[15:0];
        if (reg_idx == `PDMA_OFS_STB) stb_reg[c] <= pwdata[15:0];
        if (reg_idx == `PDMA_OFS_PAD) pad_reg[c] <= pwdata[15:0];
        if (reg_idx == `PDMA_OFS_CNT) cnt_reg[c] <= pwdata[9:0];
        if (reg_idx == `PDMA_OFS_REQ) sel_reg[c] <= pwdata[`PDMA_REQ_SEL];
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        force_reg[c] <= 1'b0;
      end else if (clk_en) begin
        if (wsel && reg_idx == `PDMA_OFS_REQ && pwdata[`PDMA_REQ_FORCE]) begin
          force_reg[c] <= 1'b1;
        end else if (done_c && forced_reg) begin
          force_reg[c] <= 1'b0;
        end
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pend_reg[c] <= 1'b0;
      end else if (clk_en) begin
        if (ctl_reg[c][`PDMA_CON_ON] && periph_req[sel_reg[c]]) begin
          pend_reg[c] <= 1'b1;
        end else if (go_reg && act_ch_reg == 2'(c) && !forced_reg) begin
          pend_reg[c] <= 1'b0;
        end
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        idx_reg[c] <= 10'h000;
        pp_reg[c] <= 1'b0;
      end else if (clk_en) begin
        if (wsel && reg_idx == `PDMA_OFS_CON) begin
          idx_reg[c] <= 10'h000;
          pp_reg[c] <= 1'b0;
        end else if (done_c) begin
          idx_reg[c] <= last_c ? 10'h000 : idx_reg[c] + 10'h001;
          if (last_c && ctl_reg[c][1]) pp_reg[c] <= ~pp_reg[c];
        end
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        block_irq[c] <= 1'b0;
      end else if (clk_en) begin
        block_irq[c] <= done_c & (ctl_reg[c][`PDMA_CON_HALF] ? half_hit : last_c);
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        periph_write_collision_reg[c] <= 1'b0;
        rwcol_reg[c] <= 1'b0;
      end else if (clk_en) begin
        if (done_c && xif.pcol) periph_write_collision_reg[c] <= 1'b1;
        else if (wr_commit && paddr[6:2] == `PDMA_OFS_CS0 && paddr[7] && !pwdata[8 + c]) periph_write_collision_reg[c] <= 1'b0;
        if (done_c && xif.rcol) rwcol_reg[c] <= 1'b1;
        else if (wr_commit && paddr[6:2] == `PDMA_OFS_CS0 && paddr[7] && !pwdata[c]) rwcol_reg[c] <= 1'b0;
      end
    end
    assign cand[c] = ctl_reg[c][`PDMA_CON_ON] & (pend_reg[c] | force_reg[c]);
  end

  // ----------------------------------------
  // arbitration and address forming
  // ----------------------------------------
  // fixed priority: channel 0 wins, lower channels can starve higher ones
  always_comb begin
    pick = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (cand[i]) pick = 2'(i);
    end
  end
  assign any_cand = |cand;
  assign base = (ctl_reg[pick][1] && pp_reg[pick]) ? stb_reg[pick] : sta_reg[pick];
  always_comb begin
    unique case (ctl_reg[pick][`PDMA_CON_ADDRESSING_SEL])
      `PDMA_AM_POSTINC: offs = ctl_reg[pick][`PDMA_CON_SIZE] ? {6'h00, idx_reg[pick]} : {5'h00, idx_reg[pick], 1'b0};
      `PDMA_AM_PERIND: offs = periph_ind_offs;
      default: offs = 16'h0000;
    endcase
  end
  assign go_ram_addr = base + offs;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      go_reg <= 1'b0;
      forced_reg <= 1'b0;
      act_ch_reg <= 2'h0;
      xif.dir <= 1'b0;
      xif.bsize <= 1'b0;
      xif.null_write_mode <= 1'b0;
      xif.ram_addr <= 16'h0000;
      xif.per_addr <= 16'h0000;
    end else if (clk_en) begin
      go_reg <= 1'b0;
      if (xif.done) busy_reg <= 1'b0;
      if (!busy_reg && any_cand) begin
        busy_reg <= 1'b1;
        go_reg <= 1'b1;
        act_ch_reg <= pick;
        forced_reg <= force_reg[pick] & ~pend_reg[pick];
        xif.dir <= ctl_reg[pick][`PDMA_CON_DIR];
        xif.bsize <= ctl_reg[pick][`PDMA_CON_SIZE];
        xif.null_write_mode <= ctl_reg[pick][`PDMA_CON_NULL_WRITE_MODE];
        xif.ram_addr <= go_ram_addr;
        xif.per_addr <= pad_reg[pick];
      end
    end
  end
  assign xif.go = go_reg;

  // ----------------------------------------
  // shared status
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_ch_reg <= `PDMA_LAST_NONE;
      recent_ram_address_reg <= 16'h0000;
    end else if (clk_en) begin
      if (xif.done) last_ch_reg <= {2'h0, act_ch_reg};
      if (go_reg) recent_ram_address_reg <= xif.ram_addr;
    end
  end

  pdma_engine u_engine (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .xif(xif.eng),
    .per_req(per_req),
    .per_we(per_we),
    .per_byte(per_byte),
    .per_addr(per_addr),
    .per_wdata(per_wdata),
    .per_rdata(per_rdata),
    .per_wcol(per_wcol),
    .ram_req(ram_req),
    .ram_we(ram_we),
    .ram_byte(ram_byte),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata),
    .ram_wcol(ram_wcol)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  property p_force_clear;
    (xif.done && forced_reg) |=> !force_reg[$past(act_ch_reg)] || $past(wr_commit);
  endproperty
  a_force_clear: assert property (p_force_clear) else $error("force not cleared");
  property p_last_ch;
    xif.done |=> last_ch_reg == {2'h0, $past(act_ch_reg)};
  endproperty
  a_last_ch: assert property (p_last_ch) else $error("last channel wrong");
  property p_recent_addr;
    go_reg |=> recent_ram_address_reg == ram_addr;
  endproperty
  a_recent_addr: assert property (p_recent_addr) else $error("recent address wrong");
  property p_served_on;
    (!busy_reg && any_cand) |-> ctl_reg[pick][`PDMA_CON_ON] ##1 (go_reg && busy_reg);
  endproperty
  a_served_on: assert property (p_served_on) else $error("disabled channel served");
  property p_go_to_done;
    go_reg |-> ##4 xif.done;
  endproperty
  a_go_to_done: assert property (p_go_to_done) else $error("transfer did not finish");
endmodule // pdma_top

// ### tb/pdma_far_model.sv
/*
 behavioural peripheral registers and dma ram on the far side.
 assumes the engine strobes for one cycle and reads data a cycle later.
*/
`timescale 1ns/1ns
module pdma_far_model import pdma_pkg::*; (
  input wire logic ref_clk,
  input wire logic collide,
  input wire logic per_req,
  input wire logic per_we,
  input wire pdma_word_t per_addr,
  input wire pdma_word_t per_wdata,
  output pdma_word_t per_rdata,
  output logic per_wcol,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire pdma_word_t ram_addr,
  input wire pdma_word_t ram_wdata,
  output pdma_word_t ram_rdata,
  output logic ram_wcol
);
  pdma_word_t per [0:15];
  pdma_word_t ram [0:255];
  // collisions only when the bench asks, in the write strobe cycle
  assign per_wcol = collide & per_req & per_we;
  assign ram_wcol = collide & ram_req & ram_we;
  always @(posedge ref_clk) begin
    // idle bus toggles so a stale word never looks valid
    per_rdata <= (per_req & !per_we) ? per[per_addr[3:0]] : ~per_rdata;
    ram_rdata <= (ram_req & !ram_we) ? ram[ram_addr[7:0]] : ~ram_rdata;
    if (per_req & per_we)
      per[per_addr[3:0]] <= per_wdata;
    if (ram_req & ram_we)
      ram[ram_addr[7:0]] <= ram_wdata;
  end
endmodule // pdma_far_model

// ### tb/pdma_test.sv
/*
 self-checking bench: apb register tasks, forced and requested blocks.
 assumes the far-side model and a 100 mhz clock.
*/
`timescale 1ns/1ns
module pdma_test import pdma_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, collide = 1'b0;
  logic clk_en = 1'b1;
  logic per_byte, ram_byte;
  int byte_wr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, re, per_req, per_we, per_wcol, ram_req, ram_we, ram_wcol;
  logic [127:0] periph_req = 128'h0;
  pdma_word_t periph_ind_offs = 16'h0000;
  pdma_word_t per_addr, per_wdata, per_rdata, ram_addr, ram_wdata, ram_rdata;
  logic [3:0] block_irq;
  int errors = 0, total_checks = 0;
  int irq_cnt [4] = '{0, 0, 0, 0};
  pdma_top uut (.ref_clk, .reset_n, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .periph_req, .periph_ind_offs, .per_req, .per_we, .per_byte,
    .per_addr, .per_wdata, .per_rdata, .per_wcol, .ram_req, .ram_we, .ram_byte, .ram_addr,
    .ram_wdata, .ram_rdata, .ram_wcol, .block_irq);
  pdma_far_model mem (.ref_clk, .collide, .per_req, .per_we, .per_addr, .per_wdata, .per_rdata,
    .per_wcol, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .ram_wcol);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++)
      if (block_irq[i] === 1'b1)
        irq_cnt[i]++;
    // byte-wide write strobes on the ram bus
    if (ram_we === 1'b1 && ram_byte === 1'b1 && per_byte === 1'b1)
      byte_wr++;
  end
  // ----------------------------------------
  // bus tasks and compare
  // ----------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung access
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(rv, x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    periph_req[i] <= 1'b1;
    @(posedge ref_clk);
    periph_req[i] <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(4);
    rdc(8'h04, 32'h0000007F);
    rdc(8'h84, 32'h00000F00);
    rdc(8'h80, 32'h00000000);
    rdc(8'h90, 32'h00000000);
    chk({31'h0, re}, 32'h1);
    $display("test reset done");
    mem.ram[8'h10] = 16'hC3A5;
    wr(8'h08, 32'h10);
    wr(8'h10, 32'h4);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'hA001);
    wr(8'h04, 32'h807F);
    idle(12);
    chk(mem.per[4], 32'hC3A5);
    rdc(8'h04, 32'h0000007F);
    rdc(8'h00, 32'h00002001);
    rdc(8'h84, 32'h00000000);
    rdc(8'h88, 32'h00000010);
    chk(irq_cnt[0], 32'h1);
    $display("test forced ram to peripheral done");
    wr(8'h28, 32'h20);
    wr(8'h30, 32'h2);
    wr(8'h34, 32'h3);
    wr(8'h24, 32'h0B);
    pulse(11);
    idle(10);
    rdc(8'h84, 32'h00000000);
    wr(8'h20, 32'hD800);
    for (int k = 1; k <= 5; k++) begin
      mem.per[2] = 16'h5A00 | 16'(k);
      pulse(11);
      idle(10);
      if (k == 2)
        chk(irq_cnt[1], 32'h1);
    end
    chk(mem.ram[8'h20], 32'h5);
    chk(mem.ram[8'h23], 32'h4);
    chk(mem.per[2], 32'h0);
    chk(byte_wr, 32'h5);
    rdc(8'h84, 32'h00000100);
    $display("test requested byte blocks done");
    for (int c = 2; c < 4; c++) begin
      wr(8'(c * 32 + 8), 32'(c * 32));
      wr(8'(c * 32 + 12), 32'(c * 32 + 16));
      wr(8'(c * 32 + 16), 32'(8 + c));
      wr(8'(c * 32 + 20), 32'h0);
      wr(8'(c * 32), (c == 2) ? 32'h8013 : 32'h8012);
      for (int j = 0; j < 3; j++) begin
        mem.per[8 + c] = 16'(c * 16 + j);
        wr(8'(c * 32 + 4), 32'h807F);
        idle(12);
      end
      chk(mem.ram[8'(c * 32)], 32'(c * 16 + ((c == 2) ? 0 : 2)));
      chk(mem.ram[8'(c * 32 + 16)], 32'(c * 16 + 1));
      rdc(8'(c * 32), (c == 2) ? 32'h0013 : 32'h8012);
    end
    $display("test ping-pong done");
    periph_ind_offs <= 16'h0006;
    mem.per[4] = 16'h7E7E;
    wr(8'h08, 32'h80);
    mem.ram[8'h86] = 16'h0000;
    wr(8'h00, 32'h8021);
    wr(8'h04, 32'h807F);
    // frozen clock enable: the forced transfer must wait
    clk_en <= 1'b0;
    idle(20);
    chk(mem.ram[8'h86], 32'h0);
    clk_en <= 1'b1;
    idle(12);
    chk(mem.ram[8'h86], 32'h7E7E);
    rdc(8'h88, 32'h00000086);
    $display("test peripheral indirect done");
    collide <= 1'b1;
    wr(8'h00, 32'h8001);
    wr(8'h04, 32'h807F);
    idle(12);
    wr(8'h20, 32'hA001);
    wr(8'h24, 32'h800B);
    idle(12);
    collide <= 1'b0;
    rdc(8'h80, 32'h00000201);
    wr(8'h80, 32'h0);
    rdc(8'h80, 32'h00000000);
    $display("test collisions done");
    complete_run;
  end
  initial begin
    repeat (6000) @(posedge ref_clk);
    errors++;
    complete_run;
  end
endmodule // pdma_test
